// [core/mlc_clock_ctrl.sv]
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
module mlc_clock_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ref_tick,
	input  wire logic [2:0]  pd_mode,
	input  wire logic        first_crystal_pin,
	input  wire logic        fast_crystal_running,
	input  wire logic        slow_crystal_osc,
	input  wire logic        slow_crystal_ready,
	input  wire logic        slow_rc_osc,
	input  wire logic        slow_rc_ready,
	input  wire logic        synth_lf_in,
	input  wire logic        lf_pin_analog,
	input  wire logic        lf_pin_digital,
	output logic             fast_crystal_osc_en,
	output logic             fast_rc_osc_en,
	output logic             mcu_clk_from_pin,
	output logic             mcu_clk_from_xtal,
	output logic             mcu_pin_clk,
	output logic             mcu_clk_en,
	output logic             fast_crystal_active_irq,
	output logic             fast_crystal_wakeup,
	output logic             low_freq_clock,
	output logic             low_freq_ready,
	output logic             mcu_start_hold,
	output logic             timers_run
);
	import mlc_pkg::*;

	// Three-stage synchronisers, value accepted when stages two and three agree
	logic [MLC_SYNC_W-1:0] s1_r, s2_r, s3_r, syn_r, syn_nxt;
	logic [MLC_SYNC_W-1:0] raw;

	assign raw = {lf_pin_digital, lf_pin_analog, synth_lf_in, slow_rc_ready,
		slow_rc_osc, slow_crystal_ready, slow_crystal_osc, fast_crystal_running,
		first_crystal_pin};

	always_comb begin
		syn_nxt = syn_r;
		for (int i = 0; i < MLC_SYNC_W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				syn_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r  <= MLC_SYNC_RST;
			s2_r  <= MLC_SYNC_RST;
			s3_r  <= MLC_SYNC_RST;
			syn_r <= MLC_SYNC_RST;
		end else begin
			s1_r  <= raw;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			syn_r <= syn_nxt;
		end
	end

	logic xc1_s, xrun_s, sx_clk_s, sx_rdy_s, sr_clk_s, sr_rdy_s, syn_clk_s, pa_s, pd_s;
	assign {pd_s, pa_s, syn_clk_s, sr_rdy_s, sr_clk_s, sx_rdy_s, sx_clk_s, xrun_s,
		xc1_s} = syn_r;

	// APB register access, zero wait states
	logic        wr_en, rd_setup, hit_mcu, hit_lf;
	logic [7:0]  mcu_cfg_r, mcu_cfg_nxt;
	logic [2:0]  lf_src_r, lf_src_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [7:0]  lf_rd;

	// Unmapped addresses answer with an error and read as zero
	assign hit_mcu  = paddr == {2'b00, MLC_ADDR_MCU_CFG};
	assign hit_lf   = paddr == {2'b00, MLC_ADDR_LF_CFG};
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !(hit_mcu || hit_lf);
	assign prdata   = prdata_r;

	always_comb begin
		mcu_cfg_nxt = mcu_cfg_r;
		lf_src_nxt  = lf_src_r;
		prdata_nxt  = prdata_r;
		if (wr_en && hit_mcu) begin
			mcu_cfg_nxt = pwdata[7:0] & MLC_MCU_CFG_WMASK;
		end
		if (wr_en && hit_lf) begin
			lf_src_nxt = pwdata[2:0];
		end
		if (rd_setup) begin
			prdata_nxt = 32'h0000_0000;
			if (hit_mcu) begin
				prdata_nxt[7:0] = mcu_cfg_r;
			end else if (hit_lf) begin
				prdata_nxt[7:0] = lf_rd;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mcu_cfg_r <= MLC_MCU_CFG_RST;
			lf_src_r  <= MLC_LF_SRC_RST;
			prdata_r  <= 32'h0000_0000;
		end else begin
			mcu_cfg_r <= mcu_cfg_nxt;
			lf_src_r  <= lf_src_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	// Start field applied on entry to retention or deep sleep
	logic [1:0] start_act_r, start_act_nxt;
	logic [2:0] pd_prev_r;
	logic       ret_entry, deep_or_mem;

	// Modes in which the fast crystal is stopped
	function automatic logic mlc_xtal_stops(input logic [2:0] mode);
		mlc_xtal_stops = mode == MLC_PD_DEEP || mode == MLC_PD_MEM_OFF
			|| mode == MLC_PD_MEM_ON;
	endfunction : mlc_xtal_stops

	// Only a step out of active mode applies a pending start field
	assign ret_entry   = pd_prev_r == MLC_PD_ACTIVE
		&& (mlc_xtal_stops(pd_mode) || pd_mode == MLC_PD_REG_RET);
	assign deep_or_mem = mlc_xtal_stops(pd_mode);

	always_comb begin
		start_act_nxt = start_act_r;
		if (ret_entry) begin
			start_act_nxt = mcu_cfg_r[MLC_POS_START+:2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_act_r <= MLC_START_BOTH;
			pd_prev_r   <= MLC_PD_ACTIVE;
		end else begin
			start_act_r <= start_act_nxt;
			pd_prev_r   <= pd_mode;
		end
	end

	// Oscillator enables and automatic RC-to-crystal hand-over
	logic xtal_act_r, xtal_act_nxt, irq_r, irq_nxt;

	always_comb begin
		case (start_act_r)
			MLC_START_XTAL: begin
				fast_crystal_osc_en = 1'b1;
				fast_rc_osc_en      = 1'b0;
			end
			MLC_START_RC: begin
				fast_crystal_osc_en = 1'b0;
				fast_rc_osc_en      = 1'b1;
			end
			default: begin
				fast_crystal_osc_en = 1'b1;
				fast_rc_osc_en      = 1'b1;
			end
		endcase
		xtal_act_nxt = fast_crystal_osc_en && xrun_s;
		irq_nxt = xtal_act_nxt && !xtal_act_r && mcu_cfg_r[MLC_BIT_XWAKE];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_act_r <= 1'b0;
			irq_r      <= 1'b0;
		end else begin
			xtal_act_r <= xtal_act_nxt;
			irq_r      <= irq_nxt;
		end
	end

	// Interrupt and wakeup share one pulse when the crystal turns active
	assign fast_crystal_active_irq = irq_r;
	assign fast_crystal_wakeup     = irq_r;
	// Bypass overrides both oscillators
	assign mcu_clk_from_pin  = mcu_cfg_r[MLC_BIT_BYPASS];
	assign mcu_clk_from_xtal = !mcu_cfg_r[MLC_BIT_BYPASS] && xtal_act_r;
	assign mcu_pin_clk       = mcu_cfg_r[MLC_BIT_BYPASS] && xc1_s;

	// MCU clock divider on the 16 MHz reference tick
	logic [6:0] div_cnt_r, div_cnt_nxt;
	logic [2:0] div_act_r, div_act_nxt;
	logic       en_r, en_nxt;

	// Period change waits for the running period to end
	function automatic logic [6:0] mlc_div_last(input logic [2:0] code);
		mlc_div_last = 7'((8'h01 << code) - 8'h01);
	endfunction : mlc_div_last

	always_comb begin
		div_cnt_nxt = div_cnt_r;
		div_act_nxt = div_act_r;
		en_nxt      = 1'b0;
		if (ref_tick) begin
			if (div_cnt_r >= mlc_div_last(div_act_r)) begin
				div_cnt_nxt = 7'h00;
				en_nxt      = 1'b1;
				div_act_nxt = mcu_cfg_r[2:0];
			end else begin
				div_cnt_nxt = 7'(div_cnt_r + 7'h01);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= MLC_DIV_RST;
			div_act_r <= MLC_MCU_CFG_RST[2:0];
			en_r      <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			div_act_r <= div_act_nxt;
			en_r      <= en_nxt;
		end
	end

	assign mcu_clk_en = en_r;

	// Low-frequency clock source selection
	logic lf_clk_r, lf_clk_nxt, lf_rdy_r, lf_rdy_nxt, lf_sel;

	always_comb begin
		lf_clk_nxt = 1'b0;
		lf_rdy_nxt = 1'b0;
		case (lf_src_r)
			MLC_LF_SLOW_XTAL: begin
				lf_clk_nxt = sx_clk_s;
				lf_rdy_nxt = sx_rdy_s;
			end
			MLC_LF_SLOW_RC: begin
				lf_clk_nxt = sr_clk_s;
				lf_rdy_nxt = sr_rdy_s;
			end
			MLC_LF_SYNTH: begin
				lf_rdy_nxt = xtal_act_r && !deep_or_mem;
				lf_clk_nxt = lf_rdy_nxt && syn_clk_s;
			end
			MLC_LF_PIN_ANA: begin
				lf_clk_nxt = pa_s;
				lf_rdy_nxt = 1'b1;
			end
			MLC_LF_PIN_DIG: begin
				lf_clk_nxt = pd_s;
				lf_rdy_nxt = 1'b1;
			end
			default: begin
				lf_clk_nxt = 1'b0;
				lf_rdy_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_clk_r <= 1'b0;
			lf_rdy_r <= 1'b0;
		end else begin
			lf_clk_r <= lf_clk_nxt;
			lf_rdy_r <= lf_rdy_nxt;
		end
	end

	// Reserved and none codes count as no source
	function automatic logic mlc_lf_valid(input logic [2:0] src);
		mlc_lf_valid = src == MLC_LF_SLOW_XTAL || src == MLC_LF_SLOW_RC
			|| src == MLC_LF_SYNTH || src == MLC_LF_PIN_ANA
			|| src == MLC_LF_PIN_DIG;
	endfunction : mlc_lf_valid

	assign lf_sel = mlc_lf_valid(lf_src_r);

	always_comb begin
		lf_rd                = 8'h00;
		lf_rd[MLC_BIT_PHASE] = lf_clk_r;
		lf_rd[MLC_BIT_READY] = lf_rdy_r;
		lf_rd[MLC_BIT_XACT]  = xtal_act_r;
		lf_rd[2:0]           = lf_src_r;
	end
	assign low_freq_clock = lf_clk_r;
	assign low_freq_ready = lf_rdy_r;
	assign mcu_start_hold = lf_sel && !lf_rdy_r;
	assign timers_run     = pd_mode != MLC_PD_REG_RET || (lf_sel && lf_rdy_r);

endmodule : mlc_clock_ctrl
`default_nettype wire

// [core/mlc_pkg.sv]
package mlc_pkg;
	localparam logic [7:0] MLC_IDX_MCU_CFG = 8'hA3;
	localparam logic [7:0] MLC_IDX_LF_CFG  = 8'hAD;
	localparam logic [9:0] MLC_ADDR_MCU_CFG = {MLC_IDX_MCU_CFG, 2'b00};
	localparam logic [9:0] MLC_ADDR_LF_CFG  = {MLC_IDX_LF_CFG, 2'b00};
	localparam logic [7:0] MLC_MCU_CFG_RST = 8'h00;
	localparam logic [2:0] MLC_LF_SRC_RST  = 3'h7;
	localparam logic [7:0] MLC_MCU_CFG_WMASK = 8'hBF;
	localparam int MLC_BIT_BYPASS = 7;
	localparam int MLC_POS_START  = 4;
	localparam int MLC_BIT_XWAKE  = 3;
	localparam int MLC_BIT_PHASE  = 7;
	localparam int MLC_BIT_READY  = 6;
	localparam int MLC_BIT_XACT   = 3;
	localparam logic [1:0] MLC_START_BOTH  = 2'h0;
	localparam logic [1:0] MLC_START_RC    = 2'h1;
	localparam logic [1:0] MLC_START_XTAL  = 2'h2;
	localparam logic [2:0] MLC_LF_SLOW_XTAL = 3'h0;
	localparam logic [2:0] MLC_LF_SLOW_RC   = 3'h1;
	localparam logic [2:0] MLC_LF_SYNTH     = 3'h2;
	localparam logic [2:0] MLC_LF_PIN_ANA   = 3'h3;
	localparam logic [2:0] MLC_LF_PIN_DIG   = 3'h4;
	localparam logic [2:0] MLC_PD_ACTIVE    = 3'h0;
	localparam logic [2:0] MLC_PD_DEEP      = 3'h1;
	localparam logic [2:0] MLC_PD_MEM_OFF   = 3'h2;
	localparam logic [2:0] MLC_PD_MEM_ON    = 3'h3;
	localparam logic [2:0] MLC_PD_REG_RET   = 3'h4;
	localparam int MLC_SYNC_W = 9;
	localparam logic [MLC_SYNC_W-1:0] MLC_SYNC_RST = '0;
	localparam logic [6:0] MLC_DIV_RST = 7'h00;
endpackage : mlc_pkg

// [dv/mlc_clock_ctrl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module mlc_clock_ctrl_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0]  pd_mode,
	input wire logic        fast_crystal_osc_en,
	input wire logic        fast_rc_osc_en,
	input wire logic        mcu_clk_from_pin,
	input wire logic        mcu_pin_clk,
	input wire logic        mcu_clk_en,
	input wire logic        fast_crystal_active_irq,
	input wire logic        fast_crystal_wakeup,
	input wire logic        low_freq_ready,
	input wire logic        mcu_start_hold
);
	import mlc_pkg::*;
	logic wr_mcu;
	assign wr_mcu = psel && penable && pwrite && paddr == {2'h0, MLC_ADDR_MCU_CFG};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	bypass_bit_a: assert property (wr_mcu |=> mcu_clk_from_pin == $past(pwdata[7]))
		else $error("bypass bit not applied");
	pin_gate_a: assert property (!mcu_clk_from_pin |-> !mcu_pin_clk)
		else $error("pin clock passed without bypass");
	osc_on_a: assert property (fast_crystal_osc_en || fast_rc_osc_en)
		else $error("both fast oscillators off");
	start_defer_a: assert property ($changed(fast_rc_osc_en) |-> $past(pd_mode) != 3'h0)
		else $error("start field applied while active");
	irq_pair_a: assert property (fast_crystal_active_irq == fast_crystal_wakeup)
		else $error("wakeup and interrupt differ");
	irq_pulse_a: assert property (fast_crystal_active_irq |=> !fast_crystal_active_irq)
		else $error("interrupt pulse too long");
	clk_en_gap_a: assert property (mcu_clk_en |=> !mcu_clk_en [*3])
		else $error("clock enable faster than reference");
	start_hold_a: assert property (low_freq_ready |-> !mcu_start_hold)
		else $error("start held with clock ready");
endmodule : mlc_clock_ctrl_asserts
bind mlc_clock_ctrl mlc_clock_ctrl_asserts u_chk (.*);
`default_nettype wire

// [dv/mlc_clock_ctrl_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module mlc_clock_ctrl_bench;
	import mlc_pkg::*;
	localparam logic [11:0] MA = {2'h0, MLC_ADDR_MCU_CFG};
	localparam logic [11:0] LA = {2'h0, MLC_ADDR_LF_CFG};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_tick = 0, er, b;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, r, seed = 3;
	logic [2:0]  pd_mode = '0;
	logic [1:0]  tc = '0;
	logic [7:0]  w;
	logic first_crystal_pin = 0, fast_crystal_running = 0, slow_crystal_osc = 0;
	logic slow_crystal_ready = 0, slow_rc_osc = 0, slow_rc_ready = 0, synth_lf_in = 0;
	logic lf_pin_analog = 0, lf_pin_digital = 0, pready, pslverr, fast_crystal_osc_en;
	logic fast_rc_osc_en, mcu_clk_from_pin, mcu_clk_from_xtal, mcu_pin_clk, mcu_clk_en;
	logic fast_crystal_active_irq, fast_crystal_wakeup, low_freq_clock, low_freq_ready;
	logic mcu_start_hold, timers_run;
	int n_errors = 0, checks = 0, k;
	mlc_clock_ctrl dut (.*);
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		tc <= tc + 2'h1;
		ref_tick <= (tc == 2'h3);
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic stop_test();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic ck(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask : ck
	task automatic ap(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		logic [31:0] v;
		n = 0;
		v = xs();
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {v[31:8], d};
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			n_errors++;
			stop_test();
		end
	endtask : ap
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wt
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		ap(0, MA, 0);
		ck(rd, 0);
		ap(0, LA, 0);
		ck(rd, 32'h07);
		for (int c = 0; c < 8; c++) begin
			r = xs();
			w = {1'b0, r[6:3], c[2:0]};
			ap(1, MA, w);
			ap(0, MA, 0);
			ck(rd, {24'h0, w & MLC_MCU_CFG_WMASK});
			wt(520);
			k = 0;
			repeat (512) begin
				wt(1);
				if (mcu_clk_en === 1'b1) k++;
			end
			ck(k, 128 >> c);
		end
		ap(1, MA, 8'h80);
		first_crystal_pin <= 1;
		wt(8);
		ck({mcu_clk_from_pin, mcu_pin_clk}, 2'b11);
		ap(1, MA, 8'h00);
		wt(8);
		ck({mcu_clk_from_pin, mcu_pin_clk}, 2'b00);
		for (int e = 0; e < 2; e++) begin
			@(posedge pclk);
			fast_crystal_running <= 0;
			ap(1, MA, {4'h0, e[0], 3'h0});
			wt(8);
			ck(mcu_clk_from_xtal, 0);
			@(posedge pclk);
			fast_crystal_running <= 1;
			k = 0;
			repeat (16) begin
				wt(1);
				if (fast_crystal_active_irq === 1'b1) k++;
			end
			ck(k, e);
			ck(mcu_clk_from_xtal, 1);
			ap(0, LA, 0);
			ck(rd[3], 1);
		end
		ap(1, MA, 8'h20);
		wt(4);
		ck({fast_crystal_osc_en, fast_rc_osc_en}, 2'b11);
		@(posedge pclk);
		pd_mode <= MLC_PD_REG_RET;
		wt(4);
		@(posedge pclk);
		pd_mode <= MLC_PD_ACTIVE;
		wt(4);
		ck({fast_crystal_osc_en, fast_rc_osc_en}, 2'b10);
		@(posedge pclk);
		slow_crystal_ready <= 1;
		slow_rc_ready <= 1;
		for (int s = 0; s < 5; s++) begin
			r = xs();
			b = r[0];
			{slow_crystal_osc, slow_rc_osc, synth_lf_in, lf_pin_analog, lf_pin_digital} <= {5{b}};
			ap(1, LA, s[7:0]);
			wt(10);
			ap(0, LA, 0);
			ck(rd[7:6], {b, 1'b1});
			ck(rd[2:0], s[2:0]);
			ck(mcu_start_hold, 0);
		end
		for (int t = 0; t < 4; t++) begin
			@(posedge pclk);
			lf_pin_digital <= t[0];
			wt(8);
			ck(low_freq_clock, t[0]);
		end
		ap(1, MA, 8'h00);
		pd_mode <= MLC_PD_REG_RET;
		wt(4);
		ck(timers_run, 1);
		ck({fast_crystal_osc_en, fast_rc_osc_en}, 2'b11);
		ap(1, LA, 8'h07);
		wt(4);
		ck(timers_run, 0);
		@(posedge pclk);
		pd_mode <= MLC_PD_ACTIVE;
		ap(1, LA, 8'h02);
		pd_mode <= MLC_PD_DEEP;
		wt(10);
		ck(low_freq_ready, 0);
		@(posedge pclk);
		pd_mode <= MLC_PD_ACTIVE;
		slow_rc_ready <= 0;
		ap(1, LA, 8'h01);
		wt(10);
		ck({low_freq_ready, mcu_start_hold}, 2'b01);
		@(posedge pclk);
		fast_crystal_running <= 0;
		wt(10);
		ap(0, LA, 0);
		ck(rd[3], 0);
		ap(1, 12'h004, 8'hFF);
		ck(er, 1);
		ap(0, 12'h004, 0);
		ck(er, 1);
		ck(rd, 0);
		stop_test();
	end
endmodule : mlc_clock_ctrl_bench
`default_nettype wire
